//--- pfe_pkg.sv
// shared constants, types and helpers for the program and erase sequencer
package pfe_pkg;

   // -----------------------------------------------------------------
   // command opcodes
   // -----------------------------------------------------------------
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_PAGE_PROG    = 8'h02;
   localparam logic [7:0] OP_QUAD_PROG    = 8'h32;
   localparam logic [7:0] OP_ERASE_4K     = 8'h20;
   localparam logic [7:0] OP_ERASE_32K    = 8'h52;
   localparam logic [7:0] OP_ERASE_64K    = 8'hD8;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;

   // -----------------------------------------------------------------
   // frame layout
   // -----------------------------------------------------------------
   localparam logic [5:0] OPCODE_BITS  = 6'h08;
   localparam logic [5:0] HDR_BITS     = 6'h20;
   localparam logic [5:0] OPCODE_LAST  = 6'h07;
   localparam logic [5:0] ADDR_LO_LAST = 6'h1F;
   localparam int unsigned PAGE_BYTES  = 256;

   // erase region masks: low bits inside the block are dropped
   localparam logic [23:0] MASK_4K  = 24'hFFF000;
   localparam logic [23:0] MASK_32K = 24'hFF8000;
   localparam logic [23:0] MASK_64K = 24'hFF0000;
   localparam logic [23:0] ADDR_RST = 24'h000000;

   // -----------------------------------------------------------------
   // self-timed durations
   // -----------------------------------------------------------------
   localparam int unsigned CORE_CLK_MHZ          = 40;
   localparam int unsigned PAGE_PROGRAM_TIME_US  = 1000;
   localparam int unsigned BLOCK_ERASE_TIME_US   = 100000;
   localparam int unsigned CHIP_ERASE_TIME_US    = 10000000;
   localparam int unsigned PAGE_PROGRAM_CYC      = PAGE_PROGRAM_TIME_US * CORE_CLK_MHZ;
   localparam int unsigned BLOCK_ERASE_CYC       = BLOCK_ERASE_TIME_US * CORE_CLK_MHZ;
   localparam int unsigned CHIP_ERASE_CYC        = CHIP_ERASE_TIME_US * CORE_CLK_MHZ;

   typedef enum logic [2:0] {
      ERASE_NONE = 3'b000,
      ERASE_4K   = 3'b001,
      ERASE_32K  = 3'b010,
      ERASE_64K  = 3'b011,
      ERASE_CHIP = 3'b100
   } pfe_erase_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PROG = 2'b01,
      ST_WAIT = 2'b10
   } pfe_state_t;

   function automatic logic is_prog_op(input logic [7:0] op);
      return (op == OP_PAGE_PROG) || (op == OP_QUAD_PROG);
   endfunction

endpackage

//--- pfe_buf_if.sv
// carrier between the link receiver and the sequencer core
`timescale 1ns/100ps
interface pfe_buf_if;
   logic [7:0]  opcode;     // last captured opcode
   logic [23:0] addr;       // last captured address
   logic [5:0]  hdr_cnt;    // header bits seen, saturates at 32
   logic [2:0]  bit_ph;     // bits into current data byte
   logic [8:0]  nbytes;     // whole data bytes, saturates at 256
   logic        frame_tog;  // flips on first clock of each frame
   logic [7:0]  rd_idx;     // page buffer read index
   logic [7:0]  rd_data;    // page buffer byte
   logic        rd_mask;    // byte was written this frame
   logic        lock;       // buffer frozen while busy

   modport link (output opcode, addr, hdr_cnt, bit_ph, nbytes, frame_tog, rd_data, rd_mask,
                 input rd_idx, lock);
   modport core (input opcode, addr, hdr_cnt, bit_ph, nbytes, frame_tog, rd_data, rd_mask,
                 output rd_idx, lock);
endinterface

//--- pfe_sync.sv
// two-flop level synchroniser
`timescale 1ns/100ps
module pfe_sync #(
   parameter int   W       = 1,
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic         clk_i,    // destination clock
   input  wire logic         rst_n_i,  // async reset, active low
   input  wire logic [W-1:0] d_i,      // foreign level
   output logic      [W-1:0] q_o       // synchronised level
);
   logic [W-1:0] meta;

   if (W < 1) begin : g_chk
      $error("pfe_sync width must be at least one");
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= {W{RST_VAL}};
         q_o  <= {W{RST_VAL}};
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule

//--- pfe_link_rx.sv
// serial link receiver: header capture and page buffer on the link clock
`timescale 1ns/100ps
module pfe_link_rx (
   input  wire logic       sclk_i,       // link clock from host
   input  wire logic       cs_n_i,       // chip select, active low
   input  wire logic       rst_n_i,      // async reset, active low
   input  wire logic [3:0] data_line_i,  // data lines, bit 0 is the single line
   pfe_buf_if.link         bif           // to the core
);
   logic         started;
   logic [5:0]   hdr_cnt;
   logic [2:0]   bit_ph;
   logic [8:0]   nbytes;
   logic [7:0]   sh;
   logic [7:0]   opcode;
   logic [7:0]   wr_ptr;
   logic [23:0]  addr;
   logic         frame_tog;
   logic [255:0] mask;
   logic [7:0]   mem [pfe_pkg::PAGE_BYTES];
   logic         lock;
   logic         quad;
   logic         in_hdr;
   logic         buf_we;
   logic [7:0]   hdr_sh;
   logic [7:0]   next_sh;
   logic [2:0]   next_ph;

   pfe_sync #(.W(1), .RST_VAL(1'b0)) u_lock (
      .clk_i   (sclk_i),
      .rst_n_i (rst_n_i),
      .d_i     (bif.lock),
      .q_o     (lock)
   );

   // the frame's own select ends it; no link clock edge is needed after it
   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         started <= 1'b0;
      end else begin
         started <= 1'b1;
      end
   end

   always_comb begin
      quad    = (opcode == pfe_pkg::OP_QUAD_PROG);
      in_hdr  = !started || (hdr_cnt < pfe_pkg::HDR_BITS);
      hdr_sh  = {sh[6:0], data_line_i[0]};
      next_sh = quad ? {sh[3:0], data_line_i} : hdr_sh;
      next_ph = bit_ph + (quad ? 3'h4 : 3'h1);
      buf_we  = !in_hdr && (next_ph == 3'h0) && pfe_pkg::is_prog_op(opcode) && !lock;
   end

   // -----------------------------------------------------------------
   // header and byte counting
   // -----------------------------------------------------------------
   always_ff @(posedge sclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hdr_cnt   <= 6'h00;
         bit_ph    <= 3'h0;
         nbytes    <= 9'h000;
         sh        <= 8'h00;
         opcode    <= 8'h00;
         addr      <= pfe_pkg::ADDR_RST;
         wr_ptr    <= 8'h00;
         frame_tog <= 1'b0;
      end else if (!started) begin
         hdr_cnt   <= 6'h01;
         sh        <= hdr_sh;
         bit_ph    <= 3'h0;
         nbytes    <= 9'h000;
         frame_tog <= ~frame_tog;
      end else if (hdr_cnt < pfe_pkg::HDR_BITS) begin
         hdr_cnt <= hdr_cnt + 6'h01;
         sh      <= hdr_sh;
         if (hdr_cnt == pfe_pkg::OPCODE_LAST) begin
            opcode <= hdr_sh;
         end
         if (hdr_cnt >= pfe_pkg::OPCODE_BITS) begin
            addr <= {addr[22:0], data_line_i[0]};
         end
         if (hdr_cnt == pfe_pkg::ADDR_LO_LAST) begin
            wr_ptr <= hdr_sh;
         end
      end else begin
         sh     <= next_sh;
         bit_ph <= next_ph;
         if ((next_ph == 3'h0) && !nbytes[8]) begin
            nbytes <= nbytes + 9'h001;
         end
         if (buf_we) begin
            wr_ptr <= wr_ptr + 8'h01;
         end
      end
   end

   // -----------------------------------------------------------------
   // page buffer
   // -----------------------------------------------------------------
   // program data buffered
   always_ff @(posedge sclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask <= '0;
      end else if (started && (hdr_cnt == pfe_pkg::OPCODE_LAST)
                   && pfe_pkg::is_prog_op(hdr_sh) && !lock) begin
         mask <= '0;
      end else if (buf_we) begin
         mask[wr_ptr] <= 1'b1;
      end
   end

   always_ff @(posedge sclk_i) begin
      if (buf_we) begin
         mem[wr_ptr] <= next_sh;
      end
   end

   // read only while the frame is over, so the contents stand still
   assign bif.opcode    = opcode;
   assign bif.addr      = addr;
   assign bif.hdr_cnt   = hdr_cnt;
   assign bif.bit_ph    = bit_ph;
   assign bif.nbytes    = nbytes;
   assign bif.frame_tog = frame_tog;
   assign bif.rd_data   = mem[bif.rd_idx];
   assign bif.rd_mask   = mask[bif.rd_idx];
endmodule

//--- pfe_core.sv
// program and erase sequencer top: command checks, latch, busy and array ops
//
// What this block does
// - opcode 02h, three address bytes, then one to 256 data bytes buffered
// - data past page end wraps to the start of the same page
// - more than a page sent keeps only the last 256 bytes
// - program at select release; unsent page bytes stay erased
// - abort with no write on short address, no data, or odd bit count
// - protected target: no program, back to idle at select release
// - latch cleared on every program abort or protection refusal, except quad program refused for lack of quad enable
// - busy during program; latch cleared before the cycle ends
// - quad program 32h needs quad enable and latch; data on four lines
// - quad program skipped unless select rises after a whole byte
// - write in progress one during quad program, zero after; latch cleared
// - quad program refused on a protected page
// - opcodes 20h, 52h, D8h erase 4, 32, 64 kbyte blocks
// - erase ignores address bits inside the selected block
// - erase needs full address and byte boundary; extra bytes ignored
// - protected erase skipped; latch cleared on any erase abort
// - erase sets region to ones, self-timed from select release
// - 60h and C7h both chip erase, no address, extra bytes ignored
// - chip erase skipped, latch cleared, if off boundary or protected
// - busy during erase, latch cleared before done; host polls
// - write enable 06h sets the latch at select release
// - program or erase refused while the latch is clear
`timescale 1ns/100ps
module pfe_core #(
   parameter int unsigned PAGE_PROG_CYCLES   = pfe_pkg::PAGE_PROGRAM_CYC,
   parameter int unsigned BLOCK_ERASE_CYCLES = pfe_pkg::BLOCK_ERASE_CYC,
   parameter int unsigned CHIP_ERASE_CYCLES  = pfe_pkg::CHIP_ERASE_CYC
) (
   input  wire logic        core_clk_i,                // core clock, 40 MHz
   input  wire logic        rst_n_i,                   // async reset, active low
   input  wire logic        sclk_i,                    // link clock from host
   input  wire logic        cs_n_i,                    // chip select, active low
   input  wire logic [3:0]  data_line_i,               // serial data lines
   input  wire logic        quad_lane_enable_i,        // quad enable status bit
   input  wire logic [4:0]  block_protect_setting_i,   // block protect bits
   output logic             write_enable_latch_o,      // latch state
   output logic             write_in_progress_flag_o,  // busy
   output logic             prog_valid_o,              // one byte to program
   output logic [23:0]      prog_addr_o,               // byte address
   output logic [7:0]       prog_data_o,               // byte value
   output logic             erase_valid_o,             // erase start pulse
   output logic [23:0]      erase_addr_o,              // region base
   output pfe_pkg::pfe_erase_t erase_size_o            // region size
);
   pfe_buf_if bif ();

   pfe_pkg::pfe_state_t state;
   pfe_pkg::pfe_state_t next_state;
   logic        cs_s;
   logic        cs_q;
   logic        tog_s;
   logic        tog_seen;
   logic        frame_end;
   logic        op_done;
   logic        hdr_done;
   logic        on_bound;
   logic        prot;
   logic        gate_ok;
   logic        is_blk;
   logic        is_chip;
   logic        qe_ok;
   logic        prog_shape;
   logic        acc_prog;
   logic        acc_erase;
   logic        fail_cmd;
   logic        set_wel;
   logic [7:0]  idx;
   logic [15:0] page;
   logic [31:0] timer;
   logic [31:0] erase_cyc;
   pfe_pkg::pfe_erase_t kind;

   if ((PAGE_PROG_CYCLES < 1) || (BLOCK_ERASE_CYCLES < 1)
       || (CHIP_ERASE_CYCLES < 1)) begin : g_chk
      $error("pfe_core cycle counts must be at least one");
   end

   // -----------------------------------------------------------------
   // link side and crossings
   // -----------------------------------------------------------------
   pfe_link_rx u_link (
      .sclk_i      (sclk_i),
      .cs_n_i      (cs_n_i),
      .rst_n_i     (rst_n_i),
      .data_line_i (data_line_i),
      .bif         (bif)
   );

   pfe_sync #(.W(1), .RST_VAL(1'b1)) u_cs (
      .clk_i   (core_clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (cs_n_i),
      .q_o     (cs_s)
   );

   pfe_sync #(.W(1), .RST_VAL(1'b0)) u_tog (
      .clk_i   (core_clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (bif.frame_tog),
      .q_o     (tog_s)
   );

   // a select pulse with no clock in it leaves stale counts; the toggle tells
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cs_q     <= 1'b1;
         tog_seen <= 1'b0;
      end else begin
         cs_q <= cs_s;
         if (cs_s && !cs_q) begin
            tog_seen <= tog_s;
         end
      end
   end

   // -----------------------------------------------------------------
   // command checks at frame end
   // -----------------------------------------------------------------
   always_comb begin
      frame_end = cs_s && !cs_q && (tog_s != tog_seen);
      op_done   = bif.hdr_cnt >= pfe_pkg::OPCODE_BITS;
      hdr_done  = bif.hdr_cnt == pfe_pkg::HDR_BITS;
      on_bound  = hdr_done ? (bif.bit_ph == 3'h0) : (bif.hdr_cnt[2:0] == 3'h0);
      // any protect code counts as whole array protected
      prot      = |block_protect_setting_i;
      gate_ok   = frame_end && op_done && write_enable_latch_o && (state == pfe_pkg::ST_IDLE);
      is_chip   = (bif.opcode == pfe_pkg::OP_CHIP_ERASE_A)
                  || (bif.opcode == pfe_pkg::OP_CHIP_ERASE_B);
      qe_ok     = (bif.opcode != pfe_pkg::OP_QUAD_PROG) || quad_lane_enable_i;
      prog_shape = hdr_done && (bif.nbytes != 9'h000) && on_bound;
      kind      = pfe_pkg::ERASE_NONE;
      erase_cyc = 32'(BLOCK_ERASE_CYCLES);
      is_blk    = 1'b1;
      case (bif.opcode)
         pfe_pkg::OP_ERASE_4K: begin
            kind = pfe_pkg::ERASE_4K;
         end
         pfe_pkg::OP_ERASE_32K: begin
            kind = pfe_pkg::ERASE_32K;
         end
         pfe_pkg::OP_ERASE_64K: begin
            kind = pfe_pkg::ERASE_64K;
         end
         default: begin
            is_blk = 1'b0;
            if (is_chip) begin
               kind      = pfe_pkg::ERASE_CHIP;
               erase_cyc = 32'(CHIP_ERASE_CYCLES);
            end
         end
      endcase
      acc_prog  = gate_ok && pfe_pkg::is_prog_op(bif.opcode) && qe_ok && prog_shape && !prot;
      acc_erase = gate_ok && !prot
                  && ((is_blk && hdr_done && on_bound) || (is_chip && on_bound));
      fail_cmd  = gate_ok && !acc_prog && !acc_erase
                  && ((pfe_pkg::is_prog_op(bif.opcode) && qe_ok) || is_blk || is_chip);
      set_wel   = frame_end && op_done && on_bound
                  && (bif.opcode == pfe_pkg::OP_WRITE_ENABLE);
   end

   // -----------------------------------------------------------------
   // write enable latch
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         write_enable_latch_o <= 1'b0;
      end else if (set_wel) begin
         write_enable_latch_o <= 1'b1;
      end else if (acc_prog || acc_erase || fail_cmd) begin
         write_enable_latch_o <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // self-timed sequence
   // -----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         pfe_pkg::ST_IDLE: begin
            if (acc_prog) begin
               next_state = pfe_pkg::ST_PROG;
            end else if (acc_erase) begin
               next_state = pfe_pkg::ST_WAIT;
            end
         end
         pfe_pkg::ST_PROG: begin
            if (idx == 8'hFF) begin
               next_state = pfe_pkg::ST_WAIT;
            end
         end
         pfe_pkg::ST_WAIT: begin
            if (timer <= 32'h00000001) begin
               next_state = pfe_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = pfe_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= pfe_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         write_in_progress_flag_o <= 1'b0;
         bif.lock                 <= 1'b0;
      end else begin
         write_in_progress_flag_o <= next_state != pfe_pkg::ST_IDLE;
         bif.lock                 <= next_state != pfe_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer <= 32'h00000000;
      end else if (acc_prog && (state == pfe_pkg::ST_IDLE)) begin
         timer <= 32'(PAGE_PROG_CYCLES);
      end else if (acc_erase && (state == pfe_pkg::ST_IDLE)) begin
         timer <= erase_cyc;
      end else if ((state == pfe_pkg::ST_WAIT) && (timer != 32'h00000000)) begin
         timer <= timer - 32'h00000001;
      end
   end

   // -----------------------------------------------------------------
   // page write-out
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idx  <= 8'h00;
         page <= 16'h0000;
      end else if (state == pfe_pkg::ST_IDLE) begin
         idx <= 8'h00;
         if (acc_prog) begin
            page <= bif.addr[23:8];
         end
      end else if (state == pfe_pkg::ST_PROG) begin
         idx <= idx + 8'h01;
      end
   end

   assign bif.rd_idx = idx;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prog_valid_o <= 1'b0;
         prog_addr_o  <= pfe_pkg::ADDR_RST;
         prog_data_o  <= 8'h00;
      end else begin
         prog_valid_o <= (state == pfe_pkg::ST_PROG) && bif.rd_mask;
         prog_addr_o  <= {page, idx};
         prog_data_o  <= bif.rd_data;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         erase_valid_o <= 1'b0;
         erase_addr_o  <= pfe_pkg::ADDR_RST;
         erase_size_o  <= pfe_pkg::ERASE_NONE;
      end else begin
         erase_valid_o <= acc_erase && (state == pfe_pkg::ST_IDLE);
         if (acc_erase && (state == pfe_pkg::ST_IDLE)) begin
            erase_size_o <= kind;
            case (kind)
               pfe_pkg::ERASE_4K: begin
                  erase_addr_o <= bif.addr & pfe_pkg::MASK_4K;
               end
               pfe_pkg::ERASE_32K: begin
                  erase_addr_o <= bif.addr & pfe_pkg::MASK_32K;
               end
               pfe_pkg::ERASE_64K: begin
                  erase_addr_o <= bif.addr & pfe_pkg::MASK_64K;
               end
               default: begin
                  erase_addr_o <= pfe_pkg::ADDR_RST;
               end
            endcase
         end
      end
   end
endmodule

//--- pfe_chk.sv
// port assertions for the program and erase sequencer
`timescale 1ns/100ps
module pfe_chk (
   input wire logic                core_clk_i,               // core clock
   input wire logic                rst_n_i,                  // reset, active low
   input wire logic                cs_n_i,                   // chip select
   input wire logic [4:0]          block_protect_setting_i,  // protect bits
   input wire logic                write_enable_latch_o,     // latch
   input wire logic                write_in_progress_flag_o, // busy
   input wire logic                prog_valid_o,             // program byte
   input wire logic                erase_valid_o,            // erase start
   input wire logic [23:0]         erase_addr_o,             // region base
   input wire pfe_pkg::pfe_erase_t erase_size_o              // region size
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   erase_busy_a: assert property (erase_valid_o |-> write_in_progress_flag_o
      && !write_enable_latch_o) else $error("erase start without busy");
   prog_busy_a: assert property (prog_valid_o |-> write_in_progress_flag_o)
      else $error("program byte outside busy");
   start_latch_a: assert property ($rose(write_in_progress_flag_o)
      |-> $past(write_enable_latch_o)) else $error("busy without latch");
   erase_mask_a: assert property (erase_valid_o && erase_size_o == pfe_pkg::ERASE_4K
      |-> erase_addr_o[11:0] == 12'h000) else $error("erase base not masked");
   chip_addr_a: assert property (erase_valid_o && erase_size_o == pfe_pkg::ERASE_CHIP
      |-> erase_addr_o == 24'h000000) else $error("chip erase base not zero");
   erase_release_a: assert property (erase_valid_o |-> $past(cs_n_i, 3))
      else $error("erase before select release");
   prot_block_a: assert property (erase_valid_o || prog_valid_o
      |-> block_protect_setting_i == 5'h00) else $error("operation while protected");
   latch_clear_a: assert property ($fell(write_enable_latch_o) |-> cs_n_i)
      else $error("latch cleared inside a frame");
   busy_hold_a: assert property ($rose(write_in_progress_flag_o)
      |-> write_in_progress_flag_o [*8]) else $error("busy dropped early");
endmodule
bind pfe_core pfe_chk u_chk (.*);

//--- pfe_host.sv
// host model: select, link clock and data lines
`timescale 1ns/100ps
module pfe_host (
   output logic       sclk_o,  // link clock, low outside frames
   output logic       cs_n_o,  // chip select, active low
   output logic [3:0] dat_o    // data lines
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      dat_o  = 4'h0;
   end
   task automatic put(input logic [3:0] v);
      dat_o = v;
      #15 sclk_o = 1'b1;
      #15 sclk_o = 1'b0;
   endtask
   // header bits, data bytes A0h upward, then loose bits
   task automatic frame(input logic [7:0] op, input logic [23:0] a,
                        input int hb, input int nb, input int xb, input bit q);
      logic [31:0] h;
      logic [7:0]  b;
      h = {op, a};
      cs_n_o = 1'b0;
      #15;
      for (int i = 0; i < hb; i++)
         put({3'h0, h[31-i]});
      for (int n = 0; n < nb; n++) begin
         b = 8'hA0 + 8'(n);
         if (q) begin
            put(b[7:4]);
            put(b[3:0]);
         end else
            for (int i = 7; i >= 0; i--)
               put({3'h0, b[i]});
      end
      for (int i = 0; i < xb; i++)
         put(4'h1);
      #15 cs_n_o = 1'b1;
      // released lines must not keep the last value
      dat_o = ~dat_o;
   endtask
endmodule

//--- pfe_core_test.sv
// self-checking bench for the program and erase sequencer
`timescale 1ns/100ps
module pfe_core_test;
   logic                core_clk_i, rst_n_i, sclk, cs_n, qe, write_enable_latch, write_in_progress_flag, pv, ev;
   logic [3:0]          dl;
   logic [4:0]          bp;
   logic [23:0]         pa, ea;
   logic [7:0]          pd;
   pfe_pkg::pfe_erase_t es;
   logic [31:0]         pq[$];
   int                  n_mismatch = 0, samples_checked = 0, ne = 0;
   pfe_host u_pfe_host (.sclk_o(sclk), .cs_n_o(cs_n), .dat_o(dl));
   pfe_core #(.PAGE_PROG_CYCLES(20), .BLOCK_ERASE_CYCLES(30), .CHIP_ERASE_CYCLES(40))
      u_pfe_core (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .data_line_i(dl), .quad_lane_enable_i(qe), .block_protect_setting_i(bp),
      .write_enable_latch_o(write_enable_latch), .write_in_progress_flag_o(write_in_progress_flag), .prog_valid_o(pv),
      .prog_addr_o(pa), .prog_data_o(pd), .erase_valid_o(ev), .erase_addr_o(ea),
      .erase_size_o(es));
   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      if (pv === 1'b1)
         pq.push_back({pa, pd});
      if (ev === 1'b1)
         ne++;
   end
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error %0t: got %h expected %h", $time, s, e);
      end
   endtask
   // bounded wait for the self-timed cycle to end
   task automatic fin();
      idle(8);
      for (int i = 0; i < 400 && write_in_progress_flag !== 1'b0; i++)
         idle(1);
      chk(write_in_progress_flag, 0);
      idle(4);
   endtask
   task automatic wen();
      u_pfe_host.frame(8'h06, 24'h0, 8, 0, 0, 0);
      fin();
   endtask
   task automatic t_refuse();
      u_pfe_host.frame(8'h02, 24'h000010, 32, 1, 0, 0);
      fin();
      chk(pq.size(), 0);
   endtask
   task automatic t_prog();
      wen();
      chk(write_enable_latch, 1);
      u_pfe_host.frame(8'h02, 24'h0123FE, 32, 3, 0, 0);
      idle(8);
      chk({write_in_progress_flag, write_enable_latch}, 2'b10);
      fin();
      chk(pq.size(), 3);
      chk(pq[0], {24'h012300, 8'hA2});
      chk(pq[1], {24'h0123FE, 8'hA0});
      chk(write_in_progress_flag, 0);
   endtask
   task automatic t_abort();
      pq.delete();
      wen();
      u_pfe_host.frame(8'h02, 24'h0, 32, 1, 3, 0);
      fin();
      chk(write_enable_latch, 0);
      wen();
      u_pfe_host.frame(8'h02, 24'h0, 20, 0, 4, 0);
      fin();
      chk({31'(pq.size()), write_enable_latch}, 0);
   endtask
   task automatic t_erase();
      logic [7:0]  op [5] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
      logic [23:0] mk [5] = '{24'hFFF000, 24'hFF8000, 24'hFF0000, 24'h0, 24'h0};
      logic [2:0]  sz [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h4};
      for (int k = 0; k < 5; k++) begin
         wen();
         u_pfe_host.frame(op[k], 24'h123456, k < 3 ? 32 : 8, 1, 0, 0);
         idle(8);
         chk({es, ea, write_enable_latch}, {sz[k], 24'h123456 & mk[k], 1'b0});
         fin();
         chk(ne, k + 1);
      end
   endtask
   task automatic t_prot();
      @(posedge core_clk_i) bp <= 5'h01;
      wen();
      u_pfe_host.frame(8'hD8, 24'h0, 32, 0, 0, 0);
      fin();
      chk({ne[30:0], write_enable_latch}, {31'd5, 1'b0});
      wen();
      u_pfe_host.frame(8'hC7, 24'h0, 8, 0, 0, 0);
      fin();
      chk({ne[30:0], write_enable_latch}, {31'd5, 1'b0});
      wen();
      u_pfe_host.frame(8'h02, 24'h0, 32, 1, 0, 0);
      fin();
      chk({31'(pq.size()), write_enable_latch}, 0);
      @(posedge core_clk_i) bp <= 5'h00;
   endtask
   task automatic t_quad();
      pq.delete();
      wen();
      u_pfe_host.frame(8'h32, 24'h000200, 32, 1, 0, 1);
      fin();
      chk({31'(pq.size()), write_enable_latch}, 1);
      @(posedge core_clk_i) qe <= 1'b1;
      u_pfe_host.frame(8'h32, 24'h000200, 32, 1, 0, 1);
      fin();
      chk(pq[0], {24'h000200, 8'hA0});
      pq.delete();
      wen();
      u_pfe_host.frame(8'h32, 24'h000200, 32, 1, 1, 1);
      fin();
      chk({31'(pq.size()), write_enable_latch}, 0);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #1000000;
      n_mismatch++;
      final_report();
   end
   initial begin
      rst_n_i = 1'b0;
      qe = 1'b0;
      bp = 5'h00;
      repeat (20) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      idle(4);
      t_refuse();
      t_prog();
      t_abort();
      t_erase();
      t_prot();
      t_quad();
      final_report();
   end
endmodule
